// ==== dv/tb.sv ====
// Self-checking bench for the calibration and sync control block
`timescale 1ns/1ps
module tb;
   logic clock = 1'b0, arst_n = 1'b0, ref_tick = 1'b0, sync_n = 1'b1, hsel, hwrite, hready, hresp;
   logic cal_clk_en, cal_start, cnt_rst_async, cnt_rst_sync;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [2:0] hsize, r_path_delay, n_path_delay;
   logic [1:0] htrans;
   int error_cnt = 0, comparisons = 0, cs, ce;
   // Clock, and a reference tick every other cycle
   initial forever #50 clock = ~clock;
   always @(posedge clock) ref_tick <= !ref_tick;
   vcs_host u_host (.*);
   vcs_ctrl u_vcs_ctrl (.*, .hreadyout(hready));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
   endtask
   // Buffered write, then the transfer strobe
   task upd(input logic [11:0] i, input logic [7:0] d);
      u_host.xfer(1'b1, i, d, q);
      u_host.xfer(1'b1, vcs_pkg::IDX_TRANSFER, 8'h01, q);
   endtask
   task watch(input int n);
      {cs, ce} = 0;
      repeat (n) @(posedge clock) {cs, ce} = {cs + cal_start, ce + cal_clk_en};
   endtask
   task t_cal;
      u_host.xfer(1'b0, vcs_pkg::IDX_CAL_CTRL, 8'h00, q);
      chk(q, 32'h06);
      upd(vcs_pkg::IDX_CAL_CTRL, 8'h06);
      u_host.xfer(1'b1, vcs_pkg::IDX_CAL_CTRL, 8'h07, q);
      u_host.xfer(1'b0, vcs_pkg::IDX_ACTIVE, 8'h00, q);
      watch(8);
      chk(q + cs, 32'h06);
      // Second strobe with start still set must stay silent
      for (int k = 1; k >= 0; k--) begin
         u_host.xfer(1'b1, vcs_pkg::IDX_TRANSFER, 8'h01, q);
         watch(8);
         chk(cs, k);
      end
      $display("cal done");
   endtask
   task t_div;
      for (int c = 0; c < 4; c++) begin
         upd(vcs_pkg::IDX_CAL_CTRL, 8'(c << 1));
         watch(40);
         watch(64);
         chk(ce, 32 >> (c + 1));
      end
      $display("div done");
   endtask
   task t_sync;
      for (int m = 0; m < 4; m++) begin
         upd(vcs_pkg::IDX_CNT_SYNC, {2'(m), 6'h2A});
         sync_n <= 1'b0;
         watch(4);
         chk({cnt_rst_sync, cnt_rst_async}, {m == 2, m == 1});
         sync_n <= 1'b1;
         watch(4);
         chk({r_path_delay, n_path_delay, cnt_rst_sync, cnt_rst_async}, 32'hA8);
      end
      $display("sync done");
   endtask
   initial begin
      repeat (12) @(posedge clock);
      arst_n <= 1'b1;
      repeat (2) @(posedge clock);
      t_cal;
      t_div;
      t_sync;
      complete_run;
   end
   task complete_run;
      $display("checks %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
endmodule

// ==== dv/vcs_ctrl_monitor.sv ====
// Port checker for the calibration and sync control block
`timescale 1ns/1ps
module vcs_chk (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic ref_tick,
   input wire logic sync_n,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic cal_clk_en,
   input wire logic cal_start,
   input wire logic cnt_rst_async,
   input wire logic cnt_rst_sync
);
   // One clock, quiet during reset
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   resp_okay_a: assert property (!hresp) else $error("resp");
   zero_wait_a: assert property ($past(arst_n) |-> hreadyout) else $error("wait");
   start_pulse_a: assert property (cal_start |=> !cal_start) else $error("start");
   cal_tick_a: assert property (cal_clk_en |-> $past(ref_tick)) else $error("tick");
   cal_gap_a: assert property (cal_clk_en |=> !cal_clk_en) else $error("gap");
   async_cause_a: assert property (cnt_rst_async |-> !$past(sync_n)) else $error("async");
   sync_cause_a: assert property ($rose(cnt_rst_sync) |-> $past(ref_tick) && !$past(sync_n)) else $error("sync");
   sync_quiet_a: assert property ($past(sync_n) && $past(ref_tick) |-> !cnt_rst_sync) else $error("quiet");
   start_c: cover property (cal_start);
   async_c: cover property (cnt_rst_async);
   sync_c: cover property (cnt_rst_sync);
endmodule
bind vcs_ctrl vcs_chk u_chk (.clock, .arst_n, .ref_tick, .sync_n, .hreadyout, .hresp, .cal_clk_en, .cal_start,
   .cnt_rst_async, .cnt_rst_sync);

// ==== dv/vcs_host.sv ====
// Host model issuing single word bus transfers
`timescale 1ns/1ps
module vcs_host (
   input wire logic clock,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel = 1'b0,
   output logic [31:0] haddr = 32'h0,
   output logic [1:0] htrans = 2'h0,
   output logic hwrite = 1'b0,
   output logic [2:0] hsize = 3'h2,
   output logic [31:0] hwdata = 32'h0
);
   // Bounded waits, so a stuck slave ends the run
   task automatic xfer(input logic w, input logic [11:0] i, input logic [7:0] d, output logic [31:0] rd);
      int n = 0;
      {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 18'h0, i, 2'h0};
      do @(posedge clock); while (hready !== 1'b1 && ++n < 50);
      {htrans, hwdata} <= {2'h0, 24'h0, d};
      do @(posedge clock); while (hready !== 1'b1 && ++n < 50);
      rd = hrdata;
      if (n >= 50) begin
         tb.error_cnt++;
         tb.complete_run;
      end
   endtask
endmodule

// ==== logic/vcs_ctrl.sv ====
// Calibration clock divider, calibration trigger and counter sync control with AHB-Lite registers
`timescale 1ns/1ps
module vcs_ctrl (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic ref_tick,
   input wire logic sync_n,
   output logic cal_clk_en,
   output logic cal_start,
   output logic cnt_rst_async,
   output logic cnt_rst_sync,
   output logic [2:0] r_path_delay,
   output logic [2:0] n_path_delay
);

   // Address phase decode shared by capture and read data
   logic addr_ok;
   logic [11:0] a_idx;

   // Bus data-phase state
   logic dp_write;
   logic [11:0] dp_idx;
   logic next_dp_write;
   logic [11:0] next_dp_idx;

   // Bus answer outputs
   logic [31:0] next_hrdata;
   logic next_hreadyout;
   logic next_hresp;

   // Buffered register copies, written by software
   logic [7:0] buf_cal;
   logic [7:0] buf_sync;
   logic [7:0] next_buf_cal;
   logic [7:0] next_buf_sync;

   // Active register copies, seen by the hardware
   logic transfer_hit;
   logic [7:0] act_cal;
   logic [7:0] act_sync;
   logic [7:0] next_act_cal;
   logic [7:0] next_act_sync;

   // Calibration clock divider state
   logic [3:0] div_cnt;
   logic [3:0] next_div_cnt;
   logic [3:0] div_last;
   logic next_cal_clk_en;

   // Calibration start edge state
   logic start_prev;
   logic next_start_prev;
   logic next_cal_start;

   // Counter sync state
   logic sync_on;
   logic [1:0] sync_mode;
   logic next_cnt_rst_async;
   logic next_cnt_rst_sync;

   // Path delay outputs
   logic [2:0] next_r_path_delay;
   logic [2:0] next_n_path_delay;

   // Transfer taken only when selected, active and bus ready
   assign addr_ok = hsel && htrans[vcs_pkg::HTRANS_ACTIVE_BIT] && hready;
   assign a_idx = haddr[vcs_pkg::ADDR_LSB +: 12]; // Word index; low address bits ignored

   // Strobe acts in the data phase of its write
   assign transfer_hit = dp_write && dp_idx == vcs_pkg::IDX_TRANSFER && hwdata[vcs_pkg::TRANSFER_BIT];

   // Pin is active low; mode comes from the active copy only
   assign sync_on = !sync_n;
   assign sync_mode = act_sync[vcs_pkg::SYNC_MODE_LSB +: 2];

   // Address phase capture for the following data phase
   always_comb begin
      next_dp_write = addr_ok && hwrite;
      // Idle or unselected cycles clear the captured index
      next_dp_idx = 12'h000;
      if (addr_ok) begin
         next_dp_idx = a_idx;
      end
   end

   // Data phase bookkeeping
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         dp_write <= 1'b0;
         dp_idx <= 12'h000;
      end else begin
         dp_write <= next_dp_write;
         dp_idx <= next_dp_idx;
      end
   end

   // Writes land in the buffer only; hardware sees them after transfer
   always_comb begin
      next_buf_cal = buf_cal;
      next_buf_sync = buf_sync;
      // Unused bits of the calibration register read back as zero
      // Writes to the transfer strobe are not stored
      if (dp_write && dp_idx == vcs_pkg::IDX_CAL_CTRL) begin
         next_buf_cal = {5'h00, hwdata[2:0]};
      end else if (dp_write && dp_idx == vcs_pkg::IDX_CNT_SYNC) begin
         next_buf_sync = hwdata[7:0];
      end
   end

   // Buffered copies
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         buf_cal <= vcs_pkg::CAL_CTRL_RESET;
         buf_sync <= vcs_pkg::CNT_SYNC_RESET;
      end else begin
         buf_cal <= next_buf_cal;
         buf_sync <= next_buf_sync;
      end
   end

   // One strobe copies both buffers, so related fields change together
   always_comb begin
      next_act_cal = act_cal;
      next_act_sync = act_sync;
      // A strobe write with bit 0 low is ignored
      if (transfer_hit) begin
         next_act_cal = buf_cal;
         next_act_sync = buf_sync;
      end
   end

   // Active copies; only these drive the hardware
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         act_cal <= vcs_pkg::CAL_CTRL_RESET;
         act_sync <= vcs_pkg::CNT_SYNC_RESET;
      end else begin
         act_cal <= next_act_cal;
         act_sync <= next_act_sync;
      end
   end

   // Read data from next values so a read right after a write sees it
   always_comb begin
      next_hreadyout = 1'b1; // Zero wait states
      next_hresp = 1'b0; // Always OKAY
      next_hrdata = 32'h0000_0000;
      // Unmapped indices, the strobe index and writes return zero
      if (!addr_ok || hwrite) begin
         next_hrdata = 32'h0000_0000;
      end else if (a_idx == vcs_pkg::IDX_CAL_CTRL) begin
         next_hrdata = {24'h000000, next_buf_cal};
      end else if (a_idx == vcs_pkg::IDX_CNT_SYNC) begin
         next_hrdata = {24'h000000, next_buf_sync};
      end else if (a_idx == vcs_pkg::IDX_ACTIVE) begin
         next_hrdata = {16'h0000, next_act_sync, next_act_cal};
      end
   end

   // Bus answer registers; ready stays low while in reset
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         hrdata <= next_hrdata;
         hreadyout <= next_hreadyout;
         hresp <= next_hresp;
      end
   end

   // Terminal count of the reference divider per active code
   always_comb begin
      case (act_cal[vcs_pkg::CAL_DIV_LSB +: 2])
         vcs_pkg::CAL_DIV_2: begin
            div_last = 4'h1;
         end
         vcs_pkg::CAL_DIV_4: begin
            div_last = 4'h3;
         end
         vcs_pkg::CAL_DIV_8: begin
            div_last = 4'h7;
         end
         default: begin
            div_last = 4'hF;
         end
      endcase
   end

   // Reference ticks feed the divider; its enable paces calibration logic
   always_comb begin
      next_div_cnt = div_cnt;
      // Enable is one clock wide and stands in for the calibration clock
      next_cal_clk_en = 1'b0;
      // A code change mid-count wraps on the next tick, never hangs
      if (ref_tick) begin
         if (div_cnt >= div_last) begin
            next_div_cnt = 4'h0;
            next_cal_clk_en = 1'b1;
         end else begin
            next_div_cnt = div_cnt + 4'h1;
         end
      end
   end

   // Divider count and calibration clock enable
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         div_cnt <= 4'h0;
         cal_clk_en <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         cal_clk_en <= next_cal_clk_en;
      end
   end

   // Only a 0 to 1 change of the active bit starts calibration
   always_comb begin
      // Holding the bit at 1 across transfers gives no new pulse
      next_start_prev = act_cal[vcs_pkg::CAL_START_BIT];
      next_cal_start = act_cal[vcs_pkg::CAL_START_BIT] && !start_prev;
   end

   // Previous value resets low, like the bit, so no false start
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         start_prev <= 1'b0;
         cal_start <= 1'b0;
      end else begin
         start_prev <= next_start_prev;
         cal_start <= next_cal_start;
      end
   end

   // Async mode follows the pin; sync mode updates on reference ticks
   always_comb begin
      // Codes 00 and 11 leave both outputs low
      next_cnt_rst_async = (sync_mode == vcs_pkg::SYNC_ASYNC_RESET) && sync_on;
      next_cnt_rst_sync = cnt_rst_sync;
      // Leaving sync mode drops a held reset at once
      if (sync_mode != vcs_pkg::SYNC_SYNC_RESET) begin
         next_cnt_rst_sync = 1'b0;
      end else if (ref_tick) begin
         next_cnt_rst_sync = sync_on;
      end
   end

   // Counter reset outputs; one cycle of lag on the pin
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cnt_rst_async <= 1'b0;
         cnt_rst_sync <= 1'b0;
      end else begin
         cnt_rst_async <= next_cnt_rst_async;
         cnt_rst_sync <= next_cnt_rst_sync;
      end
   end

   // Path delays pass straight from the active copy
   always_comb begin
      // Delay fields are only carried, not used inside this block
      next_r_path_delay = act_sync[vcs_pkg::R_DELAY_LSB +: 3];
      next_n_path_delay = act_sync[vcs_pkg::N_DELAY_LSB +: 3];
   end

   // Path delay registers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         r_path_delay <= 3'h0;
         n_path_delay <= 3'h0;
      end else begin
         r_path_delay <= next_r_path_delay;
         n_path_delay <= next_n_path_delay;
      end
   end

endmodule

// ==== logic/vcs_pkg.sv ====
// Package for the calibration clock and counter sync control block
package vcs_pkg;
   // Register indices; byte address is four times the index
   localparam logic [11:0] IDX_CAL_CTRL = 12'h018;
   localparam logic [11:0] IDX_CNT_SYNC = 12'h019;
   localparam logic [11:0] IDX_ACTIVE = 12'h0FF;
   localparam logic [11:0] IDX_TRANSFER = 12'h232;
   localparam int ADDR_LSB = 2;
   // Field positions
   localparam int CAL_START_BIT = 0;
   localparam int CAL_DIV_LSB = 1;
   localparam int SYNC_MODE_LSB = 6;
   localparam int R_DELAY_LSB = 3;
   localparam int N_DELAY_LSB = 0;
   localparam int TRANSFER_BIT = 0;
   // Values after reset
   localparam logic [7:0] CAL_CTRL_RESET = 8'h06;
   localparam logic [7:0] CNT_SYNC_RESET = 8'h00;
   // Calibration divider codes
   localparam logic [1:0] CAL_DIV_2 = 2'h0;
   localparam logic [1:0] CAL_DIV_4 = 2'h1;
   localparam logic [1:0] CAL_DIV_8 = 2'h2;
   localparam logic [1:0] CAL_DIV_16 = 2'h3;
   // Counter sync modes
   localparam logic [1:0] SYNC_IGNORE = 2'h0;
   localparam logic [1:0] SYNC_ASYNC_RESET = 2'h1;
   localparam logic [1:0] SYNC_SYNC_RESET = 2'h2;
   localparam logic [1:0] SYNC_NONE = 2'h3;
   // AHB transfer type bit that marks an active transfer
   localparam int HTRANS_ACTIVE_BIT = 1;
endpackage
